/* dpll_output_phase_offset_bench.sv */
// bench: register accesses and offset output checks for dpo_top
// assumes dpo_checker is compiled alongside
`timescale 1ns/100ps
`default_nettype none
`include "dpo_defines.vh"

module dpll_output_phase_offset_bench;
    localparam int STEP = 2;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, dpll_locked_i = 1'b0;
    logic [8:0] adr_i = 9'h000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, rd;
    wire logic [31:0] dat_o;
    wire logic ack_o, clk_invert_o, ramp_busy_o, phase_buildout_en_o;
    wire logic [15:0] offset_word_o;
    wire logic [10:0] phase_frac_o;
    wire logic signed [31:0] offset_mps_o;
    wire logic [5:0] buildout_trim_value_o;
    int failures = 0, check_count = 0;

    dpo_top #(.RAMP_STEP_CYC(STEP)) dpo_top_inst (.clk_i(clk_i),
        .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .dpll_locked_i(dpll_locked_i),
        .offset_word_o(offset_word_o), .phase_frac_o(phase_frac_o),
        .clk_invert_o(clk_invert_o), .offset_mps_o(offset_mps_o),
        .ramp_busy_o(ramp_busy_o), .phase_buildout_en_o(phase_buildout_en_o),
        .buildout_trim_value_o(buildout_trim_value_o));

    // clock
    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic end_sim;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one classic bus cycle, request held until ack is sampled
    task automatic wb(input logic w, input logic [6:0] idx,
                      input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= s;
        dat_i <= {24'h0, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 100)
            chk(32'h0, 32'h1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, 4'h1);
    endtask

    task automatic rdc(input logic [6:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 8'h00, 4'hF);
        chk(rd, exp);
    endtask

    // watchdog
    initial begin
        #(8 * 20000);
        failures++;
        $display("wrong value at %0t: timeout", $time);
        end_sim();
    end

    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(`DPO_IDX_OFS_LO, 32'h0);
        rdc(`DPO_IDX_OFS_HI, 32'h0);
        rdc(`DPO_IDX_TRIM, 32'h0);
        wr(`DPO_IDX_OFS_LO, 8'hFF);
        wr(`DPO_IDX_OFS_HI, 8'hFB);
        repeat (3) @(posedge clk_i);
        chk(offset_word_o, 16'hFBFF);
        chk(offset_mps_o, 32'(-1025 * 6279));
        rdc(`DPO_IDX_APPLIED_PS, 32'(-1025 * 6279));
        chk(phase_frac_o, 11'h3FF);
        chk(clk_invert_o, 1'b0);
        wr(`DPO_IDX_OFS_HI, 8'h04);
        wr(`DPO_IDX_OFS_LO, 8'h00);
        repeat (3) @(posedge clk_i);
        chk(clk_invert_o, 1'b1);
        chk(phase_frac_o, 11'h400);
        rdc(`DPO_IDX_OFS_HI, 32'h04);
        rdc(`DPO_IDX_APPLIED, 32'h0400);
        wr(7'h10, 8'h55);
        rdc(7'h10, 32'h0);
        wr(`DPO_IDX_TRIM, 8'hFF);
        rdc(`DPO_IDX_TRIM, 32'h3F);
        chk(buildout_trim_value_o, 6'h3F);
        wb(1'b1, `DPO_IDX_TRIM, 8'h00, 4'h0);
        rdc(`DPO_IDX_TRIM, 32'h3F);
        // locked write ramps gradually
        dpll_locked_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        wr(`DPO_IDX_OFS_LO, 8'h05);
        repeat (2) @(posedge clk_i);
        chk(ramp_busy_o, 1'b1);
        chk(offset_word_o < 16'h0405, 1'b1);
        rdc(`DPO_IDX_STATUS, 32'h3);
        repeat (40) @(posedge clk_i);
        chk(offset_word_o, 16'h0405);
        rdc(`DPO_IDX_STATUS, 32'h2);
        wr(`DPO_IDX_SYNC_MON, 8'h01);
        wr(`DPO_IDX_OFS_LO, 8'h00);
        repeat (3) @(posedge clk_i);
        chk(offset_word_o, 16'h0400);
        wr(`DPO_IDX_BO_CTRL, 8'h01);
        repeat (3) @(posedge clk_i);
        chk(offset_word_o, 16'h0);
        chk(phase_buildout_en_o, 1'b1);
        wr(`DPO_IDX_OFS_HI, 8'h12);
        dpll_locked_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk(offset_word_o, 16'h0);
        rdc(`DPO_IDX_STATUS, 32'h4);
        wr(`DPO_IDX_BO_CTRL, 8'h00);
        repeat (3) @(posedge clk_i);
        chk(offset_word_o, 16'h1200);
        chk(phase_buildout_en_o, 1'b0);
        end_sim();
    end
endmodule

bind dpo_top dpo_checker dpo_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .dpll_locked_i(dpll_locked_i), .offset_word_o(offset_word_o),
    .phase_frac_o(phase_frac_o), .clk_invert_o(clk_invert_o),
    .offset_mps_o(offset_mps_o), .phase_buildout_en_o(phase_buildout_en_o),
    .buildout_trim_value_o(buildout_trim_value_o));
`default_nettype wire

/* dpo_checker_sva.sv */
// checker: bus answer and offset output relations of the offset block
// assumes binding to dpo_top on its single clock domain
`timescale 1ns/100ps
`default_nettype none
`include "dpo_defines.vh"

module dpo_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [8:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // dpll and offset outputs
    input wire logic dpll_locked_i,
    input wire logic [15:0] offset_word_o,
    input wire logic [10:0] phase_frac_o,
    input wire logic clk_invert_o,
    input wire logic signed [31:0] offset_mps_o,
    input wire logic phase_buildout_en_o,
    input wire logic [5:0] buildout_trim_value_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // request taken at this edge
    wire logic take_w = cyc_i && stb_i && !ack_o;

    a_ack_answer: assert property (take_w |=> ack_o)
        else $error("request not answered next cycle");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_frac_tracks: assert property (phase_frac_o == offset_word_o[10:0])
        else $error("fraction differs from offset word");
    a_invert_tracks: assert property (clk_invert_o == offset_word_o[10])
        else $error("inversion differs from offset bit 10");
    a_mps_scale: assert property (
        offset_mps_o == $signed(offset_word_o) * 32'sh00001887)
        else $error("picosecond value not word times 6279");
    a_trim_readzero: assert property (
        (take_w && !we_i && adr_i[8:2] == `DPO_IDX_TRIM)
        |=> dat_o[31:6] == 26'h0)
        else $error("trim top bits not zero");
    a_trim_store: assert property (
        (take_w && we_i && sel_i[0] && adr_i[8:2] == `DPO_IDX_TRIM)
        |-> ##2 buildout_trim_value_o == $past(dat_i[5:0], 2))
        else $error("trim value not stored");
    a_bo_store: assert property (
        (take_w && we_i && sel_i[0] && adr_i[8:2] == `DPO_IDX_BO_CTRL)
        |-> ##2 phase_buildout_en_o == $past(dat_i[0], 2))
        else $error("build-out enable not stored");
    a_bo_zero: assert property (
        (phase_buildout_en_o && !dpll_locked_i)[*5] |-> offset_word_o == 16'h0)
        else $error("offset applied during build-out");
endmodule
`default_nettype wire

/* dpo_defines.vh */
// Constants for the DPLL output phase offset block: register indices,
// field positions, reset values and ramp timing.
// Assumes a single 125 MHz system clock and a classic Wishbone slave port.
`ifndef DPO_DEFINES_VH
`define DPO_DEFINES_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define DPO_IDX_OFS_LO 7'h70
`define DPO_IDX_OFS_HI 7'h71
`define DPO_IDX_TRIM 7'h72
`define DPO_IDX_BO_CTRL 7'h76
`define DPO_IDX_SYNC_MON 7'h7C
`define DPO_IDX_STATUS 7'h7D
`define DPO_IDX_APPLIED 7'h7E
`define DPO_IDX_APPLIED_PS 7'h7F

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DPO_BO_EN_BIT 0
`define DPO_RAMP_DIS_BIT 0
`define DPO_ST_BUSY_BIT 0
`define DPO_ST_LOCK_BIT 1
`define DPO_ST_BO_BIT 2
`define DPO_TRIM_MSB 5
`define DPO_FRAC_MSB 10
`define DPO_INVERT_BIT 10

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DPO_RST_OFS_LO 8'h00
`define DPO_RST_OFS_HI 8'h00
`define DPO_RST_TRIM 6'h00
`define DPO_RST_BO_CTRL 8'h00
`define DPO_RST_SYNC_MON 8'h00

// ----------------------------------------------------------------------
// scaling and timing
// ----------------------------------------------------------------------
// offset LSB weight in milli-picoseconds (6.279 ps)
`define DPO_LSB_MPS 15'h1887
`define DPO_CLK_PERIOD_NS 8
// time between two single-LSB ramp steps
`define DPO_RAMP_STEP_NS 1000
`define DPO_RAMP_STEP_CYC (`DPO_RAMP_STEP_NS / `DPO_CLK_PERIOD_NS)

`endif

/* dpo_ramp.v */
// Ramp engine: moves the applied offset toward the target word, one LSB
// per step interval while ramping is allowed, otherwise in one jump.
// Assumes target and ramp enable come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "dpo_defines.vh"

module dpo_ramp #(
    parameter STEP_CYC = `DPO_RAMP_STEP_CYC
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // control
    input wire [15:0] target_i,
    input wire ramp_en_i,
    // result
    output reg [15:0] applied_o,
    output reg signed [31:0] applied_mps_o,
    output reg busy_o
);

    // ------------------------------------------------------------------
    // step timer and next applied value
    // ------------------------------------------------------------------
    reg [31:0] tick_r;
    reg [15:0] applied_nxt;
    wire signed [15:0] tgt_s = target_i;
    wire signed [15:0] app_s = applied_o;
    wire tick = (tick_r == 32'h00000000);
    wire signed [14:0] lsb_w = `DPO_LSB_MPS;
    wire signed [30:0] mps_w;

    // one step toward target per tick, or straight jump
    always @* begin
        applied_nxt = applied_o;
        if (!ramp_en_i) begin
            applied_nxt = target_i;
        end else if (tick && (tgt_s > app_s)) begin
            applied_nxt = applied_o + 16'h0001;
        end else if (tick && (tgt_s < app_s)) begin
            applied_nxt = applied_o - 16'h0001;
        end
    end

    // signed word times 6.279 ps, kept in milli-picoseconds
    assign mps_w = $signed(applied_nxt) * lsb_w;

    // state registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            tick_r <= 32'h00000000;
            applied_o <= 16'h0000;
            applied_mps_o <= 32'h00000000;
            busy_o <= 1'b0;
        end else begin
            if (tick || !ramp_en_i) begin
                tick_r <= STEP_CYC - 1;
            end else begin
                tick_r <= tick_r - 32'h00000001;
            end
            applied_o <= applied_nxt;
            applied_mps_o <= {mps_w[30], mps_w};
            busy_o <= (applied_nxt != target_i);
        end
    end

endmodule
`default_nettype wire

/* dpo_top.v */
// DPLL output phase offset control: Wishbone register file, target word
// assembly, build-out override and the phase outputs toward the DPLL.
// Assumes the lock indication comes from DPLL logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "dpo_defines.vh"

module dpo_top #(
    parameter RAMP_STEP_CYC = `DPO_RAMP_STEP_CYC
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // classic wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [8:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // dpll status
    input wire dpll_locked_i,
    // phase offset toward the output clock path
    output reg [15:0] offset_word_o,
    output reg [10:0] phase_frac_o,
    output reg clk_invert_o,
    output reg signed [31:0] offset_mps_o,
    output reg ramp_busy_o,
    // phase build-out controls
    output reg phase_buildout_en_o,
    output reg [5:0] buildout_trim_value_o
);

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    reg [7:0] ofs_lo_r;
    reg [7:0] ofs_hi_r;
    reg [5:0] trim_r;
    reg [7:0] bo_ctrl_r;
    reg [7:0] sync_mon_r;
    reg [31:0] rdata_nxt;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire [6:0] idx = adr_i[8:2];
    wire req = cyc_i && stb_i && !ack_o;
    wire wr = req && we_i && sel_i[0];

    // ------------------------------------------------------------------
    // offset word, build-out override and ramp control
    // ------------------------------------------------------------------
    wire [15:0] prog_word = {ofs_hi_r, ofs_lo_r};
    wire bo_en = bo_ctrl_r[`DPO_BO_EN_BIT];
    wire ramp_dis = sync_mon_r[`DPO_RAMP_DIS_BIT];
    // build-out mode ignores the programmed word
    wire [15:0] target = bo_en ? 16'h0000 : prog_word;
    // ramp only while locked and not turned off
    wire ramp_en = dpll_locked_i && !ramp_dis;
    wire [15:0] applied;
    wire signed [31:0] applied_mps;
    wire busy;

    // ramp engine
    dpo_ramp #(
        .STEP_CYC(RAMP_STEP_CYC)
    ) u_ramp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .target_i(target),
        .ramp_en_i(ramp_en),
        .applied_o(applied),
        .applied_mps_o(applied_mps),
        .busy_o(busy)
    );

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // byte lane 0 carries every register; unmapped writes are dropped
    always @(posedge clk_i) begin
        if (rst_i) begin
            ofs_lo_r <= `DPO_RST_OFS_LO;
            ofs_hi_r <= `DPO_RST_OFS_HI;
            trim_r <= `DPO_RST_TRIM;
            bo_ctrl_r <= `DPO_RST_BO_CTRL;
            sync_mon_r <= `DPO_RST_SYNC_MON;
        end else if (wr) begin
            if (idx == `DPO_IDX_OFS_LO) begin
                ofs_lo_r <= dat_i[7:0];
            end else if (idx == `DPO_IDX_OFS_HI) begin
                ofs_hi_r <= dat_i[7:0];
            end else if (idx == `DPO_IDX_TRIM) begin
                trim_r <= dat_i[`DPO_TRIM_MSB:0];
            end else if (idx == `DPO_IDX_BO_CTRL) begin
                bo_ctrl_r <= dat_i[7:0];
            end else if (idx == `DPO_IDX_SYNC_MON) begin
                sync_mon_r <= dat_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    // unmapped reads answer zero
    always @* begin
        rdata_nxt = 32'h00000000;
        if (idx == `DPO_IDX_OFS_LO) begin
            rdata_nxt[7:0] = ofs_lo_r;
        end else if (idx == `DPO_IDX_OFS_HI) begin
            rdata_nxt[7:0] = ofs_hi_r;
        end else if (idx == `DPO_IDX_TRIM) begin
            rdata_nxt[`DPO_TRIM_MSB:0] = trim_r;
        end else if (idx == `DPO_IDX_BO_CTRL) begin
            rdata_nxt[7:0] = bo_ctrl_r;
        end else if (idx == `DPO_IDX_SYNC_MON) begin
            rdata_nxt[7:0] = sync_mon_r;
        end else if (idx == `DPO_IDX_STATUS) begin
            rdata_nxt[`DPO_ST_BUSY_BIT] = busy;
            rdata_nxt[`DPO_ST_LOCK_BIT] = dpll_locked_i;
            rdata_nxt[`DPO_ST_BO_BIT] = bo_en;
        end else if (idx == `DPO_IDX_APPLIED) begin
            rdata_nxt[15:0] = applied;
        end else if (idx == `DPO_IDX_APPLIED_PS) begin
            rdata_nxt = applied_mps;
        end
    end

    // ------------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------------
    // ack one cycle after the request, dropped the cycle after
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= req;
            if (req && !we_i) begin
                dat_o <= rdata_nxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs toward the clock path
    // ------------------------------------------------------------------
    // each LSB is 1/2048 of the internal clock period; bit 10 is a half
    always @(posedge clk_i) begin
        if (rst_i) begin
            offset_word_o <= 16'h0000;
            phase_frac_o <= 11'h000;
            clk_invert_o <= 1'b0;
            offset_mps_o <= 32'h00000000;
            ramp_busy_o <= 1'b0;
            phase_buildout_en_o <= 1'b0;
            buildout_trim_value_o <= 6'h00;
        end else begin
            offset_word_o <= applied;
            phase_frac_o <= applied[`DPO_FRAC_MSB:0];
            clk_invert_o <= applied[`DPO_INVERT_BIT];
            offset_mps_o <= applied_mps;
            ramp_busy_o <= busy;
            phase_buildout_en_o <= bo_en;
            buildout_trim_value_o <= trim_r;
        end
    end

endmodule
`default_nettype wire
